// File: logic/srs_consts.svh
// Offsets, field positions, reset values and sizes of the status reporting block
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_SEL_QUES_COND  4'h0
`define SRS_SEL_QUES_EVT   4'h1
`define SRS_SEL_QUES_ENA   4'h2
`define SRS_SEL_STD_EVT    4'h3
`define SRS_SEL_STD_ENA    4'h4
`define SRS_SEL_OPER_COND  4'h5
`define SRS_SEL_OPER_EVT   4'h6
`define SRS_SEL_OPER_ENA   4'h7
`define SRS_SEL_STB        4'h8
`define SRS_SEL_SRE        4'h9
`define SRS_QUES_TEMP_BIT  4
`define SRS_STD_OPC_BIT    0
`define SRS_STD_QERR_BIT   2
`define SRS_STD_EXE_BIT    4
`define SRS_STD_CMD_BIT    5
`define SRS_STD_PON_BIT    7
`define SRS_OPER_MEAS_BIT  4
`define SRS_OPER_AVAIL_BIT 8
`define SRS_STB_QUES_BIT   3
`define SRS_STB_MAV_BIT    4
`define SRS_STB_ESB_BIT    5
`define SRS_STB_RQS_BIT    6
`define SRS_STB_OPER_BIT   7
`define SRS_REG_RESET      16'h0000
`define SRS_OUT_LINE_LEN   80
`endif

// File: logic/srs_pkg.sv
// Types shared by the status reporting block
package srs_pkg;
   typedef enum logic [1:0] {
      SRS_OPC_IDLE   = 2'b00,
      SRS_OPC_ACTIVE = 2'b01
   } srs_opc_e;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  sel;
      logic [15:0] wdata;
   } srs_host_req_s;
   typedef struct packed {
      logic op_done;
      logic exe_err;
      logic cmd_err;
      logic meas_start;
      logic meas_done;
      logic meas_init;
      logic fetch;
      logic temp_oor;
      logic crossed;
   } srs_events_s;
endpackage

// File: logic/srs_status_reporting.sv
// Status registers, output line buffer and service request of the instrument
`timescale 1ns/1ps
`include "srs_consts.svh"

// How it works
// RULE1: Event bit sets on a rising condition edge, otherwise holds.
// RULE2: Reading an event register clears it and its status byte summary.
// RULE3: Event bits reach summary bits only through their enable masks.
// RULE4: Standard event group has event and enable registers, no condition.
// RULE5: One response line of up to 80 characters is buffered.
// RULE6: Reading condition, enable or status byte leaves them unchanged.
// RULE7: Questionable bit 4 on out-of-range temperature or crossed wires.
// RULE8: Queries answer the binary-weighted value of the register bits.
// RULE9: Standard event bit 0 marks completion of pending operations.
// RULE10: Standard event bit 2 on empty-queue read or lost queued data.
// RULE11: Standard event bit 4 when a valid command cannot run now.
// RULE12: Standard event bit 5 when the parser rejects the command line.
// RULE13: Standard event bit 7 records a power-on transition.
// RULE14: Operation-complete command waits active, then idles and sets bit 0.
// RULE15: Operation condition bit 4 follows the measurement busy state.
// RULE16: Operation bit 8 sets on initiated measurement done, clears on fetch.
// RULE17: Host writes enable masks to pick which events are reported.
// RULE18: Status byte holds the group summaries plus the request bit.
// RULE19: Any bit set in both status byte and request mask raises SRQ.
// RULE20: Serial poll returns byte with request bit, then clears it, drops SRQ.
// RULE21: Reset command cancels pending work, idles both completion states.
// RULE22: Byte bits: 3 quest, 4 message, 5 standard, 6 request, 7 oper.
// RULE23: Message flag follows queue data, clears when emptied or flushed.
// RULE24: Clear-status zeroes events, status byte and completion states.
// RULE25: A new edge in the read-clear cycle keeps its event bit set.
module srs_status_reporting
   import srs_pkg::*;
#(
   parameter int OUT_LEN = `SRS_OUT_LINE_LEN
) (
   input  wire logic          sys_clk_i,
   input  wire logic          rst_i,
   input  wire srs_host_req_s host_req_i,
   output logic [15:0]        host_rdata_o,
   output logic               host_rvalid_o,
   input  wire srs_events_s   evt_i,
   input  wire logic          opc_cmd_i,
   input  wire logic          opc_query_i,
   input  wire logic          clr_status_i,
   input  wire logic          dev_reset_i,
   input  wire logic          ser_poll_i,
   output logic [7:0]         poll_byte_o,
   output logic               srq_o,
   input  wire logic          ob_wr_i,
   input  wire logic [7:0]    ob_wdata_i,
   input  wire logic          ob_eol_i,
   input  wire logic          ob_rd_i,
   output logic [7:0]         ob_rdata_o,
   output logic               ob_rvalid_o,
   output logic               ob_mav_o
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   logic        rd_qev;
   logic        rd_sev;
   logic        rd_oev;
   logic        wr_qen;
   logic        wr_sen;
   logic        wr_oen;
   logic        wr_sre;
   logic [15:0] q_cond;
   logic [15:0] o_cond;
   logic [15:0] q_cond_q;
   logic [15:0] o_cond_q;
   logic [15:0] q_evt_q;
   logic [15:0] o_evt_q;
   logic [7:0]  s_evt_q;
   logic [15:0] q_en_q;
   logic [15:0] o_en_q;
   logic [7:0]  s_en_q;
   logic [7:0]  sre_q;
   logic        meas_busy_q;
   logic        avail_q;
   logic        pon_q;
   logic        rqs_q;
   logic        msg_req_q;
   logic        qerr;
   logic        ob_opc_wr;
   srs_opc_e    opc_cmd_q;
   srs_opc_e    opc_qry_q;
   logic [7:0]  stb;
   logic        mss;

   assign rd_qev = host_req_i.rd && host_req_i.sel == `SRS_SEL_QUES_EVT;
   assign rd_sev = host_req_i.rd && host_req_i.sel == `SRS_SEL_STD_EVT;
   assign rd_oev = host_req_i.rd && host_req_i.sel == `SRS_SEL_OPER_EVT;
   assign wr_qen = host_req_i.wr && host_req_i.sel == `SRS_SEL_QUES_ENA;
   assign wr_sen = host_req_i.wr && host_req_i.sel == `SRS_SEL_STD_ENA;
   assign wr_oen = host_req_i.wr && host_req_i.sel == `SRS_SEL_OPER_ENA;
   assign wr_sre = host_req_i.wr && host_req_i.sel == `SRS_SEL_SRE;

   ////////////////////////////////////////////////////////////////////////
   // Condition registers

   always_comb begin
      q_cond = 16'h0000;
      q_cond[`SRS_QUES_TEMP_BIT] = evt_i.temp_oor | evt_i.crossed; // RULE7
      o_cond = 16'h0000;
      o_cond[`SRS_OPER_MEAS_BIT]  = meas_busy_q; // RULE15
      o_cond[`SRS_OPER_AVAIL_BIT] = avail_q; // RULE16
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meas_busy_q <= 1'b0;
      end else if (evt_i.meas_start) begin
         meas_busy_q <= 1'b1; // RULE15
      end else if (evt_i.meas_done) begin
         meas_busy_q <= 1'b0; // RULE15
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avail_q <= 1'b0;
      end else if (evt_i.meas_done && evt_i.meas_init) begin
         avail_q <= 1'b1; // RULE16
      end else if (evt_i.fetch) begin
         avail_q <= 1'b0; // RULE16
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_cond_q <= `SRS_REG_RESET;
         o_cond_q <= `SRS_REG_RESET;
      end else begin
         q_cond_q <= q_cond;
         o_cond_q <= o_cond;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event registers, edge wins over read-clear

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_evt_q <= `SRS_REG_RESET;
      end else begin
         q_evt_q <= ((rd_qev || clr_status_i) ? 16'h0000 : q_evt_q) // RULE2
                    | (q_cond & ~q_cond_q); // RULE1 RULE25
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         o_evt_q <= `SRS_REG_RESET;
      end else begin
         o_evt_q <= ((rd_oev || clr_status_i) ? 16'h0000 : o_evt_q) // RULE2
                    | (o_cond & ~o_cond_q); // RULE1 RULE25
      end
   end

   // Standard group has no condition register
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_evt_q <= 8'h00;
      end else begin
         s_evt_q <= ((rd_sev || clr_status_i) ? 8'h00 : s_evt_q) | { // RULE4
            pon_q, // RULE13
            1'b0,
            evt_i.cmd_err, // RULE12
            evt_i.exe_err, // RULE11
            1'b0,
            qerr, // RULE10
            1'b0,
            opc_cmd_q == SRS_OPC_ACTIVE && evt_i.op_done}; // RULE9 RULE14
      end
   end

   // One-shot power-on marker after reset release
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pon_q <= 1'b1;
      end else begin
         pon_q <= 1'b0; // RULE13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable registers, written by the host

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_en_q <= `SRS_REG_RESET;
         o_en_q <= `SRS_REG_RESET;
         s_en_q <= 8'h00;
         sre_q  <= 8'h00;
      end else begin
         if (wr_qen) q_en_q <= host_req_i.wdata; // RULE17
         if (wr_oen) o_en_q <= host_req_i.wdata; // RULE17
         if (wr_sen) s_en_q <= host_req_i.wdata[7:0]; // RULE17
         if (wr_sre) sre_q <= host_req_i.wdata[7:0]; // RULE17
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operation-complete states

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         opc_cmd_q <= SRS_OPC_IDLE;
      end else if (dev_reset_i || clr_status_i) begin
         opc_cmd_q <= SRS_OPC_IDLE; // RULE21 RULE24
      end else begin
         case (opc_cmd_q)
            SRS_OPC_IDLE: begin
               if (opc_cmd_i) opc_cmd_q <= SRS_OPC_ACTIVE; // RULE14
            end
            SRS_OPC_ACTIVE: begin
               if (evt_i.op_done) opc_cmd_q <= SRS_OPC_IDLE; // RULE14
            end
            default: opc_cmd_q <= SRS_OPC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         opc_qry_q <= SRS_OPC_IDLE;
      end else if (dev_reset_i || clr_status_i) begin
         opc_qry_q <= SRS_OPC_IDLE; // RULE21 RULE24
      end else begin
         case (opc_qry_q)
            SRS_OPC_IDLE: begin
               if (opc_query_i) opc_qry_q <= SRS_OPC_ACTIVE;
            end
            SRS_OPC_ACTIVE: begin
               if (evt_i.op_done) opc_qry_q <= SRS_OPC_IDLE;
            end
            default: opc_qry_q <= SRS_OPC_IDLE;
         endcase
      end
   end

   assign ob_opc_wr = opc_qry_q == SRS_OPC_ACTIVE && evt_i.op_done;

   ////////////////////////////////////////////////////////////////////////
   // Output line buffer

   logic [7:0] ob_mem [OUT_LEN];
   logic [6:0] ob_wptr_q;
   logic [6:0] ob_rptr_q;
   logic       ob_line_q;
   logic       ob_lost_q;
   logic       ob_has;

   assign ob_has = ob_line_q && ob_rptr_q != ob_wptr_q;
   // Read of empty queue, or a write that overflows or overwrites a line
   assign qerr = (ob_rd_i && !ob_has) || ob_lost_q; // RULE10

   always_ff @(posedge sys_clk_i) begin
      if (ob_opc_wr && !ob_line_q) begin
         ob_mem[0] <= 8'h31;
      end else if (ob_wr_i && !ob_line_q && ob_wptr_q < 7'(OUT_LEN)) begin
         ob_mem[ob_wptr_q] <= ob_wdata_i; // RULE5
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ob_wptr_q <= 7'h00;
         ob_rptr_q <= 7'h00;
         ob_line_q <= 1'b0;
         ob_lost_q <= 1'b0;
      end else begin
         ob_lost_q <= 1'b0;
         if (clr_status_i) begin
            ob_wptr_q <= 7'h00; // RULE23
            ob_rptr_q <= 7'h00;
            ob_line_q <= 1'b0;
         end else if (ob_line_q) begin
            if (ob_wr_i || ob_opc_wr) ob_lost_q <= 1'b1; // RULE10
            if (ob_rd_i && ob_has) ob_rptr_q <= ob_rptr_q + 7'h01;
            if (ob_rd_i && ob_rptr_q + 7'h01 == ob_wptr_q) begin
               ob_line_q <= 1'b0; // RULE23
               ob_wptr_q <= 7'h00;
               ob_rptr_q <= 7'h00;
            end
         end else if (ob_opc_wr) begin
            ob_wptr_q <= 7'h01;
            ob_line_q <= 1'b1;
            if (ob_wr_i || ob_wptr_q != 7'h00) ob_lost_q <= 1'b1; // RULE10
         end else if (ob_wr_i) begin
            if (ob_wptr_q < 7'(OUT_LEN)) begin
               ob_wptr_q <= ob_wptr_q + 7'h01; // RULE5
            end else begin
               ob_lost_q <= 1'b1; // RULE10
            end
            if (ob_eol_i) ob_line_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ob_rdata_o  <= 8'h00;
         ob_rvalid_o <= 1'b0;
      end else begin
         ob_rvalid_o <= ob_rd_i && ob_has;
         ob_rdata_o  <= ob_has ? ob_mem[ob_rptr_q] : 8'h00;
      end
   end

   assign ob_mav_o = ob_has; // RULE23

   ////////////////////////////////////////////////////////////////////////
   // Status byte and service request

   always_comb begin
      stb = 8'h00;
      stb[`SRS_STB_QUES_BIT] = |(q_evt_q & q_en_q); // RULE3 RULE22
      stb[`SRS_STB_MAV_BIT]  = ob_has; // RULE23 RULE22
      stb[`SRS_STB_ESB_BIT]  = |(s_evt_q & s_en_q); // RULE3 RULE22
      stb[`SRS_STB_OPER_BIT] = |(o_evt_q & o_en_q); // RULE3 RULE22
   end

   assign mss = |(stb & sre_q & ~8'h40); // RULE19

   // Request latched on a new reason, cleared by poll or when reason goes
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rqs_q     <= 1'b0;
         msg_req_q <= 1'b0;
      end else begin
         msg_req_q <= mss;
         if (!mss || clr_status_i) begin
            rqs_q <= 1'b0; // RULE24
         end else if (mss && !msg_req_q) begin
            rqs_q <= 1'b1; // RULE19
         end else if (ser_poll_i) begin
            rqs_q <= 1'b0; // RULE20
         end
      end
   end

   assign srq_o = rqs_q; // RULE19

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         poll_byte_o <= 8'h00;
      end else if (ser_poll_i) begin
         poll_byte_o <= stb | {1'b0, rqs_q, 6'h00}; // RULE18 RULE20
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Query answers, read without side effect except event clear

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         host_rdata_o  <= 16'h0000;
         host_rvalid_o <= 1'b0;
      end else begin
         host_rvalid_o <= host_req_i.rd;
         if (host_req_i.sel == `SRS_SEL_QUES_COND) begin
            host_rdata_o <= q_cond_q; // RULE6 RULE8
         end else if (host_req_i.sel == `SRS_SEL_QUES_EVT) begin
            host_rdata_o <= q_evt_q; // RULE8
         end else if (host_req_i.sel == `SRS_SEL_QUES_ENA) begin
            host_rdata_o <= q_en_q; // RULE6
         end else if (host_req_i.sel == `SRS_SEL_STD_EVT) begin
            host_rdata_o <= {8'h00, s_evt_q};
         end else if (host_req_i.sel == `SRS_SEL_STD_ENA) begin
            host_rdata_o <= {8'h00, s_en_q};
         end else if (host_req_i.sel == `SRS_SEL_OPER_COND) begin
            host_rdata_o <= o_cond_q; // RULE6
         end else if (host_req_i.sel == `SRS_SEL_OPER_EVT) begin
            host_rdata_o <= o_evt_q;
         end else if (host_req_i.sel == `SRS_SEL_OPER_ENA) begin
            host_rdata_o <= o_en_q;
         end else if (host_req_i.sel == `SRS_SEL_STB) begin
            host_rdata_o <= {8'h00, stb | {1'b0, mss, 6'h00}}; // RULE6 RULE18
         end else if (host_req_i.sel == `SRS_SEL_SRE) begin
            host_rdata_o <= {8'h00, sre_q};
         end else begin
            host_rdata_o <= 16'h0000;
         end
      end
   end

endmodule

// File: testbench/srs_host_model.sv
// Host controller model: register queries, mask writes and serial polls
`timescale 1ns/1ps
module srs_host_model
   import srs_pkg::*;
(
   input  wire logic        sys_clk_i,
   output srs_host_req_s    host_req_o,
   output logic             ser_poll_o,
   input  wire logic [15:0] host_rdata_i,
   input  wire logic        host_rvalid_i,
   input  wire logic [7:0]  poll_byte_i
);
   initial begin
      host_req_o = '0;
      ser_poll_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Mask write, lines show the inverse once released
   task automatic write(input logic [3:0] s, input logic [15:0] d);
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: ~d};
   endtask
   // Query, answer taken when valid shows
   task automatic query(input logic [3:0] s, output logic [15:0] d);
      int i;
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 16'h0000};
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: 16'hffff};
      for (i = 0; i < 4 && host_rvalid_i !== 1'b1; i++) @(negedge sys_clk_i);
      d = (host_rvalid_i === 1'b1) ? host_rdata_i : 16'hxxxx;
   endtask
   // Serial poll pulse, byte taken two cycles later
   task automatic poll(output logic [7:0] b);
      @(negedge sys_clk_i) ser_poll_o = 1'b1;
      @(negedge sys_clk_i) ser_poll_o = 1'b0;
      @(negedge sys_clk_i) b = poll_byte_i;
   endtask
endmodule

// File: testbench/srs_status_chk.sv
// Port checker for the status reporting block
`timescale 1ns/1ps
module srs_status_chk
   import srs_pkg::*;
(
   input wire logic          sys_clk_i,
   input wire logic          rst_i,
   input wire srs_host_req_s host_req_i,
   input wire logic          host_rvalid_o,
   input wire logic          ser_poll_i,
   input wire logic          clr_status_i,
   input wire logic          dev_reset_i,
   input wire logic [7:0]    poll_byte_o,
   input wire logic          srq_o,
   input wire logic          ob_wr_i,
   input wire logic          ob_eol_i,
   input wire logic          ob_rd_i,
   input wire logic          ob_rvalid_o,
   input wire logic          ob_mav_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   a_query_answer: assert property (host_req_i.rd |=> host_rvalid_o)
      else $error("query not answered");
   a_answer_cause: assert property (
      host_rvalid_o |-> $past(host_req_i.rd))
      else $error("answer without query");
   a_poll_drops: assert property (ser_poll_i |-> ##[1:2] !srq_o)
      else $error("request kept after poll");
   a_poll_reports: assert property (
      ser_poll_i && srq_o |-> ##[1:2] poll_byte_o[6])
      else $error("poll byte lacks request bit");
   a_poll_stands: assert property (
      !ser_poll_i && !clr_status_i && !dev_reset_i
      |=> $stable(poll_byte_o))
      else $error("poll byte changed without poll");
   a_eol_gives_mav: assert property (
      ob_wr_i && ob_eol_i && !ob_mav_o && !clr_status_i && !dev_reset_i
      |=> ob_mav_o)
      else $error("complete line not flagged");
   a_mav_holds: assert property (
      ob_mav_o && !ob_rd_i && !clr_status_i && !dev_reset_i |=> ob_mav_o)
      else $error("message flag lost");
   a_cls_flushes: assert property (clr_status_i && !ob_wr_i |=> !ob_mav_o)
      else $error("clear left message");
   a_char_read: assert property (ob_rd_i && ob_mav_o |=> ob_rvalid_o)
      else $error("char read not answered");
   a_char_cause: assert property (ob_rvalid_o |-> $past(ob_rd_i))
      else $error("char valid without read");
endmodule
bind srs_status_reporting srs_status_chk u_chk (.sys_clk_i, .rst_i,
   .host_req_i, .host_rvalid_o, .ser_poll_i, .clr_status_i, .dev_reset_i,
   .poll_byte_o, .srq_o, .ob_wr_i, .ob_eol_i, .ob_rd_i, .ob_rvalid_o,
   .ob_mav_o);

// File: testbench/status_reporting_system_test.sv
// Self-checking bench for the status reporting block
`timescale 1ns/1ps
module status_reporting_system_test
   import srs_pkg::*;
   ;
   logic sys_clk_i = 1'b0, rst_i = 1'b1;
   srs_host_req_s host_req_i;
   logic [15:0] host_rdata_o, d;
   logic host_rvalid_o, ser_poll_i, srq_o, ob_rvalid_o, ob_mav_o;
   logic [7:0] poll_byte_o, ob_rdata_o, b, ob_wdata_i = 8'h00;
   srs_events_s evt_i = '0;
   logic opc_cmd_i = 0, opc_query_i = 0, clr_status_i = 0, dev_reset_i = 0;
   logic ob_wr_i = 0, ob_eol_i = 0, ob_rd_i = 0;
   int n_mismatch = 0, total_checks = 0, i;
   typedef struct packed {
      logic        wr;
      logic [3:0]  sel;
      logic [15:0] wdata;
      logic [15:0] exp;
   } srs_row_s;
   srs_row_s rows [8] = '{'{1, 4'h2, 16'h0010, 16'h0010},
      '{0, 4'h2, 16'h0000, 16'h0010}, '{1, 4'h4, 16'hffff, 16'h00ff},
      '{1, 4'h7, 16'h0100, 16'h0100}, '{1, 4'h9, 16'h0010, 16'h0010},
      '{1, 4'h0, 16'hffff, 16'h0000}, '{1, 4'hf, 16'hffff, 16'h0000},
      '{0, 4'h8, 16'h0000, 16'h0000}};
   srs_status_reporting uut (.sys_clk_i, .rst_i, .host_req_i, .host_rdata_o,
      .host_rvalid_o, .evt_i, .opc_cmd_i, .opc_query_i, .clr_status_i,
      .dev_reset_i, .ser_poll_i, .poll_byte_o, .srq_o, .ob_wr_i, .ob_wdata_i,
      .ob_eol_i, .ob_rd_i, .ob_rdata_o, .ob_rvalid_o, .ob_mav_o);
   srs_host_model host (.sys_clk_i, .host_req_o(host_req_i),
      .ser_poll_o(ser_poll_i), .host_rdata_i(host_rdata_o),
      .host_rvalid_i(host_rvalid_o), .poll_byte_i(poll_byte_o));
   always #5 sys_clk_i = ~sys_clk_i;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic qchk(input logic [3:0] s, input logic [15:0] e);
      host.query(s, d);
      chk(d, e);
   endtask
   // Event pulses; levels set by lvl
   task automatic pls(input srs_events_s e);
      @(negedge sys_clk_i) evt_i = evt_i | e;
      @(negedge sys_clk_i) evt_i = evt_i & ~e;
      repeat (3) @(negedge sys_clk_i);
   endtask
   task automatic lvl(input srs_events_s e);
      @(negedge sys_clk_i) evt_i = e;
      repeat (3) @(negedge sys_clk_i);
   endtask
   // Order: opc_cmd, opc_query, clr_status, dev_reset, ob_rd
   task automatic ctl(input logic [4:0] c);
      @(negedge sys_clk_i) {opc_cmd_i, opc_query_i, clr_status_i,
         dev_reset_i, ob_rd_i} = c;
      @(negedge sys_clk_i) {opc_cmd_i, opc_query_i, clr_status_i,
         dev_reset_i, ob_rd_i} = 5'h00;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task automatic line(input int n, input logic [7:0] c);
      for (int k = 0; k < n; k++) begin
         @(negedge sys_clk_i);
         ob_wr_i = 1'b1;
         ob_wdata_i = c + k[7:0];
         ob_eol_i = (k == n - 1);
      end
      @(negedge sys_clk_i) {ob_wr_i, ob_eol_i} = 2'b00;
      ob_wdata_i = ~ob_wdata_i;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task automatic drain(input int n, input logic [7:0] c);
      for (int k = 0; k < n; k++) begin
         @(negedge sys_clk_i) ob_rd_i = 1'b1;
         @(negedge sys_clk_i) ob_rd_i = 1'b0;
         if (ob_rvalid_o !== 1'b1) @(negedge sys_clk_i);
         chk({7'h00, ob_rvalid_o, ob_rdata_o}, {8'h01, c + k[7:0]});
      end
      repeat (2) @(negedge sys_clk_i);
      chk({15'h0000, ob_mav_o}, 16'h0000);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      n_mismatch++;
      test_done;
   end
   initial begin
      repeat (8) @(negedge sys_clk_i);
      rst_i = 1'b0;
      chk({14'h0000, srq_o, ob_mav_o}, 16'h0000);
      qchk(4'h3, 16'h0080);
      qchk(4'h3, 16'h0000);
      foreach (rows[r]) begin
         if (rows[r].wr) host.write(rows[r].sel, rows[r].wdata);
         qchk(rows[r].sel, rows[r].exp);
      end
      lvl(9'h002);
      qchk(4'h0, 16'h0010);
      qchk(4'h8, 16'h0008);
      qchk(4'h1, 16'h0010);
      qchk(4'h1, 16'h0000);
      qchk(4'h8, 16'h0000);
      lvl(9'h000);
      lvl(9'h001);
      qchk(4'h1, 16'h0010);
      host.write(4'h2, 16'h0000);
      lvl(9'h000);
      lvl(9'h002);
      qchk(4'h8, 16'h0000);
      lvl(9'h000);
      pls(9'h020);
      qchk(4'h5, 16'h0010);
      qchk(4'h8, 16'h0000);
      pls(9'h018);
      qchk(4'h5, 16'h0100);
      qchk(4'h8, 16'h0080);
      pls(9'h004);
      qchk(4'h5, 16'h0000);
      qchk(4'h6, 16'h0110);
      qchk(4'h1, 16'h0010);
      pls(9'h020);
      pls(9'h010);
      qchk(4'h5, 16'h0000);
      pls(9'h0c0);
      qchk(4'h8, 16'h0020);
      qchk(4'h3, 16'h0030);
      ctl(5'h10);
      pls(9'h100);
      qchk(4'h3, 16'h0001);
      pls(9'h100);
      qchk(4'h3, 16'h0000);
      for (i = 0; i < 2; i++) begin
         ctl(5'h10);
         ctl(i ? 5'h04 : 5'h02);
         pls(9'h100);
         qchk(4'h3, 16'h0000);
      end
      ctl(5'h01);
      qchk(4'h3, 16'h0004);
      fork
         host.query(4'h3, d);
         pls(9'h040);
      join
      qchk(4'h3, 16'h0020);
      line(2, 8'h41);
      for (i = 0; i < 8 && srq_o !== 1'b1; i++) @(negedge sys_clk_i);
      chk({15'h0000, srq_o}, 16'h0001);
      qchk(4'h8, 16'h0050);
      host.poll(b);
      chk({8'h00, b}, 16'h0050);
      chk({15'h0000, srq_o}, 16'h0000);
      host.poll(b);
      chk({8'h00, b}, 16'h0010);
      drain(2, 8'h41);
      line(80, 8'h20);
      qchk(4'h3, 16'h0000);
      line(1, 8'h7e);
      qchk(4'h3, 16'h0004);
      drain(80, 8'h20);
      line(81, 8'h20);
      qchk(4'h3, 16'h0004);
      drain(80, 8'h20);
      ctl(5'h08);
      pls(9'h100);
      drain(1, 8'h31);
      line(3, 8'h41);
      ctl(5'h04);
      chk({15'h0000, ob_mav_o}, 16'h0000);
      qchk(4'h8, 16'h0000);
      @(negedge sys_clk_i) rst_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      rst_i = 1'b0;
      qchk(4'h4, 16'h0000);
      qchk(4'h3, 16'h0080);
      test_done;
   end
endmodule
